// [rtl/pfd_frame_router.sv]
// routing and access policing of cpu accesses into three peripheral frames
// assumes the core, security module and peripherals share i_mclk
`timescale 1ns/1ps
`default_nettype none

module pfd_frame_router (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire pfd_pkg::pfd_cpu_req_t i_req,
    input wire logic i_open_instr,
    input wire logic i_close_instr,
    input wire logic i_csm_unlocked,
    input wire logic [pfd_pkg::DATA_W-1:0] i_f0_rdata,
    input wire logic [pfd_pkg::DATA_W-1:0] i_f1_rdata,
    input wire logic [pfd_pkg::F2_DATA_W-1:0] i_f2_rdata,
    output pfd_pkg::pfd_periph_acc_t o_f0_acc,
    output pfd_pkg::pfd_periph_acc_t o_f1_acc,
    output pfd_pkg::pfd_periph_acc_t o_f2_acc,
    output logic o_ack,
    output logic o_discard,
    output logic [pfd_pkg::DATA_W-1:0] o_rdata,
    output logic o_window_open
);

    pfd_pkg::pfd_state_t st_reg;
    pfd_pkg::pfd_state_t st_next;

    logic dec_hit;
    logic [pfd_pkg::RIDX_W-1:0] dec_idx;
    logic [1:0] dec_frame;
    logic [2:0] dec_attr;

    logic width_ok;
    logic sec_ok;
    logic wr_ok;
    logic go;
    pfd_pkg::pfd_periph_acc_t acc;

    pfd_addr_decode u_decode (
        .i_addr(i_req.addr),
        .o_hit(dec_hit),
        .o_idx(dec_idx),
        .o_frame(dec_frame),
        .o_attr(dec_attr)
    );

    // policing of the access presented this cycle
    always_comb begin
        unique case (dec_frame)
            pfd_pkg::FR_0: width_ok = 1'b1;
            pfd_pkg::FR_1: width_ok = !(dec_attr == pfd_pkg::ATTR_CAN && !i_req.wide) &&
                                      !(i_req.wide && i_req.addr[0]);
            pfd_pkg::FR_2: width_ok = !i_req.wide;
            default: width_ok = 1'b0;
        endcase
        // security lock gates reads and writes of flash control
        sec_ok = (dec_attr != pfd_pkg::ATTR_FLASH) || i_csm_unlocked;
        // reads never depend on the window
        wr_ok = !i_req.write || st_reg.window_open ||
                !(dec_attr == pfd_pkg::ATTR_PROT || dec_attr == pfd_pkg::ATTR_FLASH);
        go = dec_hit && width_ok && sec_ok && wr_ok;
        acc.valid = 1'b1;
        acc.write = i_req.write;
        acc.wide = i_req.wide;
        // partial protection is resolved per bit inside the peripheral
        acc.priv = st_reg.window_open;
        acc.ridx = dec_idx;
        acc.addr = i_req.addr;
        acc.wdata = i_req.wdata;
        if (dec_frame == pfd_pkg::FR_2) begin
            acc.wdata[pfd_pkg::DATA_W-1:pfd_pkg::F2_DATA_W] = '0;
        end
    end

    always_comb begin
        st_next = st_reg;
        st_next.f0.valid = 1'b0;
        st_next.f1.valid = 1'b0;
        st_next.f2.valid = 1'b0;
        st_next.ack = 1'b0;
        st_next.discard = 1'b0;
        st_next.rpend = 1'b0;
        st_next.dpend = 1'b0;
        // close wins when both instructions retire together
        if (i_close_instr) begin
            st_next.window_open = 1'b0;
        end else if (i_open_instr) begin
            st_next.window_open = 1'b1;
        end
        // answer stage: data captured one cycle after the strobe
        if (st_reg.rpend) begin
            st_next.ack = 1'b1;
            st_next.discard = st_reg.dpend;
            unique case (st_reg.rsrc)
                pfd_pkg::FR_0: st_next.rdata = i_f0_rdata;
                pfd_pkg::FR_1: st_next.rdata = i_f1_rdata;
                pfd_pkg::FR_2: st_next.rdata = {{(pfd_pkg::DATA_W-pfd_pkg::F2_DATA_W){1'b0}}, i_f2_rdata};
                default: st_next.rdata = '0;
            endcase
        end
        // a refused access is still answered so the bus never stalls
        if (i_req.valid) begin
            st_next.rpend = 1'b1;
            st_next.dpend = !go;
            st_next.rsrc = go ? dec_frame : pfd_pkg::FR_NONE;
            if (go) begin
                unique case (dec_frame)
                    pfd_pkg::FR_0: st_next.f0 = acc;
                    pfd_pkg::FR_1: st_next.f1 = acc;
                    pfd_pkg::FR_2: st_next.f2 = acc;
                    default: st_next.rsrc = pfd_pkg::FR_NONE;
                endcase
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else if (i_ce) begin
            st_reg <= st_next;
        end
    end

    assign o_f0_acc = st_reg.f0;
    assign o_f1_acc = st_reg.f1;
    assign o_f2_acc = st_reg.f2;
    assign o_ack = st_reg.ack;
    assign o_discard = st_reg.discard;
    assign o_rdata = st_reg.rdata;
    assign o_window_open = st_reg.window_open;

    // checks; frozen cycles are skipped by the clock qualifier
    default clocking cb @(posedge i_mclk iff i_ce);
    endclocking
    default disable iff (!i_rst_n);

    logic any_strobe;
    assign any_strobe = o_f0_acc.valid || o_f1_acc.valid || o_f2_acc.valid;

    sequence s_req_write_closed;
        i_req.valid && i_req.write && !o_window_open && !i_close_instr;
    endsequence

    sequence s_dropped;
        !any_strobe ##1 (o_ack && o_discard);
    endsequence

    sequence s_close_then_write;
        i_close_instr ##1 (i_req.valid && i_req.write && dec_attr == pfd_pkg::ATTR_PROT);
    endsequence

    a_prot_write_drop: assert property (
        s_req_write_closed and (dec_attr == pfd_pkg::ATTR_PROT) |=> s_dropped)
        else $error("protected write passed with window closed");

    a_close_blocks: assert property (
        s_close_then_write |=> s_dropped)
        else $error("protected write passed after close instruction");

    a_flash_locked: assert property (
        i_req.valid && dec_idx == pfd_pkg::RGN_FLASH && dec_hit && !i_csm_unlocked |=> s_dropped)
        else $error("flash region reached while security locked");

    a_flash_open: assert property (
        i_req.valid && i_req.write && dec_idx == pfd_pkg::RGN_FLASH && dec_hit && i_csm_unlocked &&
        o_window_open |=> o_f0_acc.valid && o_f0_acc.write)
        else $error("allowed flash write not forwarded");

    a_csm_key_prot: assert property (
        s_req_write_closed and (dec_hit && dec_idx == pfd_pkg::RGN_CSM_KEY) |=> ##1 o_discard)
        else $error("security key write not discarded");

    a_adc_dual_open: assert property (
        i_req.valid && i_req.write && dec_hit && dec_idx == pfd_pkg::RGN_ADC_DUAL |=>
        o_f0_acc.valid ##1 (o_ack && !o_discard))
        else $error("dual-mapped result write blocked");

    a_gpio_wake_prot: assert property (
        s_req_write_closed and (dec_hit && dec_idx == pfd_pkg::RGN_GPIO_WAKE) |=> !o_f1_acc.valid)
        else $error("wake select write passed with window closed");

    a_can_partial: assert property (
        i_req.valid && i_req.write && i_req.wide && !i_req.addr[0] && dec_hit &&
        dec_idx == pfd_pkg::RGN_CAN_A && !o_window_open && !i_close_instr && !i_open_instr |=>
        o_f1_acc.valid && !o_f1_acc.priv)
        else $error("can control write not forwarded unprivileged");

    a_can_wide_only: assert property (
        i_req.valid && !i_req.wide && dec_attr == pfd_pkg::ATTR_CAN && dec_hit |=> s_dropped)
        else $error("16-bit access reached can control");

    a_f2_narrow: assert property (
        i_req.valid && !i_req.write && !i_req.wide && dec_frame == pfd_pkg::FR_2 |=>
        o_f2_acc.valid && !o_f2_acc.wide)
        else $error("16-bit frame 2 read not forwarded");

    a_f2_wide_drop: assert property (
        i_req.valid && i_req.wide && dec_frame == pfd_pkg::FR_2 |=> !o_f2_acc.valid ##1 o_discard)
        else $error("wide access reached frame 2");

    a_f0_widths: assert property (
        i_req.valid && !i_req.write && dec_frame == pfd_pkg::FR_0 && dec_attr != pfd_pkg::ATTR_FLASH |=>
        o_f0_acc.valid && o_f0_acc.wide == $past(i_req.wide))
        else $error("frame 0 read of either width not forwarded");

    a_pwm_route: assert property (
        i_req.valid && i_req.write && i_req.wide && !i_req.addr[0] && dec_hit &&
        dec_idx == pfd_pkg::RGN_PWM |=> o_f1_acc.valid && !o_f0_acc.valid)
        else $error("pwm write not routed to frame 1");

    a_ack_latency: assert property (
        i_req.valid && !$past(i_req.valid) |=> !o_ack ##1 o_ack)
        else $error("answer not given two cycles after request");

endmodule : pfd_frame_router

`default_nettype wire

// [include/pfd_pkg.sv]
// constants, region map and carrier types of the peripheral frame decoder
// assumes one clock domain shared with the processor core
package pfd_pkg;

    localparam int ADDR_W = 22;
    localparam int DATA_W = 32;
    localparam int F2_DATA_W = 16;
    localparam int NREG = 27;
    localparam int RIDX_W = 5;
    localparam int RESP_LAT = 2;

    // frame codes
    localparam logic [1:0] FR_NONE = 2'h0;
    localparam logic [1:0] FR_0 = 2'h1;
    localparam logic [1:0] FR_1 = 2'h2;
    localparam logic [1:0] FR_2 = 2'h3;

    // access policy of a region
    localparam logic [2:0] ATTR_OPEN = 3'h0;
    localparam logic [2:0] ATTR_PROT = 3'h1;
    localparam logic [2:0] ATTR_PART = 3'h2;
    localparam logic [2:0] ATTR_FLASH = 3'h3;
    localparam logic [2:0] ATTR_CAN = 3'h4;

    // indices of regions named by the router's checks
    localparam logic [RIDX_W-1:0] RGN_FLASH = 5'h01;
    localparam logic [RIDX_W-1:0] RGN_CSM_KEY = 5'h02;
    localparam logic [RIDX_W-1:0] RGN_ADC_DUAL = 5'h03;
    localparam logic [RIDX_W-1:0] RGN_CAN_A = 5'h07;
    localparam logic [RIDX_W-1:0] RGN_PWM = 5'h0b;
    localparam logic [RIDX_W-1:0] RGN_GPIO_WAKE = 5'h10;

    typedef logic [ADDR_W-1:0] pfd_addr_t;

    typedef struct packed {
        pfd_addr_t first;
        pfd_addr_t last;
        logic [1:0] frame;
        logic [2:0] attr;
    } pfd_region_t;

    localparam pfd_region_t REGION_MAP [NREG] = '{
        '{22'h000880, 22'h0009ff, FR_0, ATTR_PROT},
        '{22'h000a80, 22'h000adf, FR_0, ATTR_FLASH},
        '{22'h000ae0, 22'h000aef, FR_0, ATTR_PROT},
        '{22'h000b00, 22'h000b0f, FR_0, ATTR_OPEN},
        '{22'h000c00, 22'h000c3f, FR_0, ATTR_OPEN},
        '{22'h000ce0, 22'h000cff, FR_0, ATTR_OPEN},
        '{22'h000d00, 22'h000dff, FR_0, ATTR_PROT},
        '{22'h006000, 22'h0060ff, FR_1, ATTR_CAN},
        '{22'h006100, 22'h0061ff, FR_1, ATTR_OPEN},
        '{22'h006200, 22'h0062ff, FR_1, ATTR_CAN},
        '{22'h006300, 22'h0063ff, FR_1, ATTR_OPEN},
        '{22'h006800, 22'h00697f, FR_1, ATTR_PART},
        '{22'h006a00, 22'h006a7f, FR_1, ATTR_OPEN},
        '{22'h006b00, 22'h006b7f, FR_1, ATTR_OPEN},
        '{22'h006f80, 22'h006fbf, FR_1, ATTR_PROT},
        '{22'h006fc0, 22'h006fdf, FR_1, ATTR_OPEN},
        '{22'h006fe0, 22'h006fff, FR_1, ATTR_PROT},
        '{22'h007010, 22'h00702f, FR_2, ATTR_PROT},
        '{22'h007040, 22'h00704f, FR_2, ATTR_OPEN},
        '{22'h007050, 22'h00705f, FR_2, ATTR_OPEN},
        '{22'h007070, 22'h00707f, FR_2, ATTR_OPEN},
        '{22'h007100, 22'h00711f, FR_2, ATTR_OPEN},
        '{22'h007740, 22'h00774f, FR_2, ATTR_OPEN},
        '{22'h007750, 22'h00775f, FR_2, ATTR_OPEN},
        '{22'h007760, 22'h00776f, FR_2, ATTR_OPEN},
        '{22'h007780, 22'h00778f, FR_2, ATTR_OPEN},
        '{22'h007900, 22'h00792f, FR_2, ATTR_OPEN}
    };

    // cpu data bus request, one cycle per access
    typedef struct packed {
        logic valid;
        logic write;
        logic wide;
        pfd_addr_t addr;
        logic [DATA_W-1:0] wdata;
    } pfd_cpu_req_t;

    // strobe towards one peripheral frame
    typedef struct packed {
        logic valid;
        logic write;
        logic wide;
        logic priv;
        logic [RIDX_W-1:0] ridx;
        pfd_addr_t addr;
        logic [DATA_W-1:0] wdata;
    } pfd_periph_acc_t;

    typedef struct packed {
        logic window_open;
        pfd_periph_acc_t f0;
        pfd_periph_acc_t f1;
        pfd_periph_acc_t f2;
        logic rpend;
        logic dpend;
        logic [1:0] rsrc;
        logic ack;
        logic discard;
        logic [DATA_W-1:0] rdata;
    } pfd_state_t;

endpackage : pfd_pkg

// [rtl/pfd_addr_decode.sv]
// address to region decoder of the peripheral frame decoder
// assumes the region map in pfd_pkg holds disjoint ranges
`timescale 1ns/1ps
`default_nettype none

module pfd_addr_decode (
    input wire pfd_pkg::pfd_addr_t i_addr,
    output logic o_hit,
    output logic [pfd_pkg::RIDX_W-1:0] o_idx,
    output logic [1:0] o_frame,
    output logic [2:0] o_attr
);

    logic [pfd_pkg::NREG-1:0] match;

    generate
        for (genvar g = 0; g < pfd_pkg::NREG; g++) begin : g_cmp
            assign match[g] = (i_addr >= pfd_pkg::REGION_MAP[g].first) &&
                              (i_addr <= pfd_pkg::REGION_MAP[g].last);
        end
    endgenerate

    // ranges never overlap, so at most one bit is set
    always_comb begin
        o_hit = 1'b0;
        o_idx = '0;
        o_frame = pfd_pkg::FR_NONE;
        o_attr = pfd_pkg::ATTR_OPEN;
        for (int i = 0; i < pfd_pkg::NREG; i++) begin
            if (match[i]) begin
                o_hit = 1'b1;
                o_idx = pfd_pkg::RIDX_W'(i);
                o_frame = pfd_pkg::REGION_MAP[i].frame;
                o_attr = pfd_pkg::REGION_MAP[i].attr;
            end
        end
    end

endmodule : pfd_addr_decode

`default_nettype wire

// [tb/pfd_periph_model.sv]
// peripheral side of the three frames: answers read data on a strobe
// assumes strobes are one-cycle pulses and data is taken in that cycle
`timescale 1ns/1ps
`default_nettype none

module pfd_periph_model (
    input wire pfd_pkg::pfd_periph_acc_t i_f0_acc,
    input wire pfd_pkg::pfd_periph_acc_t i_f1_acc,
    input wire pfd_pkg::pfd_periph_acc_t i_f2_acc,
    output logic [pfd_pkg::DATA_W-1:0] o_f0_rdata,
    output logic [pfd_pkg::DATA_W-1:0] o_f1_rdata,
    output logic [pfd_pkg::F2_DATA_W-1:0] o_f2_rdata
);
    // unselected frames show inverted data, so a stray sample never matches
    always_comb begin
        o_f0_rdata = {10'h2a5, i_f0_acc.addr} ^ {32{~i_f0_acc.valid}};
        o_f1_rdata = {10'h15a, i_f1_acc.addr} ^ {32{~i_f1_acc.valid}};
        o_f2_rdata = i_f2_acc.addr[15:0] ^ 16'h5a5a ^ {16{~i_f2_acc.valid}};
    end
endmodule : pfd_periph_model

`default_nettype wire

// [tb/pfd_frame_router_tb.sv]
// self-checking bench of the frame router with a peripheral model
// assumes the two-cycle answer and one-cycle strobes of the router
`timescale 1ns/1ps
`default_nettype none

module pfd_frame_router_tb;
    localparam logic [1:0] NO = pfd_pkg::FR_NONE;
    localparam logic [1:0] F0 = pfd_pkg::FR_0;
    localparam logic [1:0] F1 = pfd_pkg::FR_1;
    localparam logic [1:0] F2 = pfd_pkg::FR_2;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_ce = 1'b1;
    pfd_pkg::pfd_cpu_req_t i_req = '0;
    logic i_open_instr = 1'b0;
    logic i_close_instr = 1'b0;
    logic i_csm_unlocked = 1'b0;
    logic [31:0] f0_rdata, f1_rdata, o_rdata;
    logic [15:0] f2_rdata;
    pfd_pkg::pfd_periph_acc_t f0_acc, f1_acc, f2_acc;
    logic o_ack, o_discard, o_window_open;
    logic win = 1'b0;
    int fail_count = 0;
    int check_count = 0;

    always #10 i_mclk = ~i_mclk;

    pfd_frame_router dut_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_req(i_req),
        .i_open_instr(i_open_instr), .i_close_instr(i_close_instr), .i_csm_unlocked(i_csm_unlocked),
        .i_f0_rdata(f0_rdata), .i_f1_rdata(f1_rdata), .i_f2_rdata(f2_rdata), .o_f0_acc(f0_acc),
        .o_f1_acc(f1_acc), .o_f2_acc(f2_acc), .o_ack(o_ack), .o_discard(o_discard),
        .o_rdata(o_rdata), .o_window_open(o_window_open));

    pfd_periph_model pm_u (.i_f0_acc(f0_acc), .i_f1_acc(f1_acc), .i_f2_acc(f2_acc),
        .o_f0_rdata(f0_rdata), .o_f1_rdata(f1_rdata), .o_f2_rdata(f2_rdata));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one access waited out to its answer; frame NO means it must be refused
    task automatic acc(input logic wr, input logic wide, input pfd_pkg::pfd_addr_t a, input logic [1:0] fr);
        pfd_pkg::pfd_periph_acc_t s;
        logic [31:0] rd;
        @(negedge i_mclk);
        i_req <= '{valid: 1'b1, write: wr, wide: wide, addr: a, wdata: {10'h0cc, a}};
        @(negedge i_mclk);
        i_req.valid <= 1'b0;
        chk("strobes", {29'h0, fr == F0, fr == F1, fr == F2}, {29'h0, f0_acc.valid, f1_acc.valid, f2_acc.valid});
        s = (fr == F2) ? f2_acc : (fr == F1) ? f1_acc : f0_acc;
        rd = (fr == F2) ? {16'h0, a[15:0] ^ 16'h5a5a} : (fr == F1) ? {10'h15a, a} : {10'h2a5, a};
        if (fr != NO) begin
            chk("fields", {7'h0, win, wr, wide, a}, {7'h0, s.priv, s.write, s.wide, s.addr});
            chk("wdata", (fr == F2) ? {16'h0, a[15:0]} : {10'h0cc, a}, s.wdata);
            chk("ridx", 32'h1, {31'h0, a >= pfd_pkg::REGION_MAP[s.ridx].first && a <= pfd_pkg::REGION_MAP[s.ridx].last});
        end
        @(negedge i_mclk);
        chk("answer", {30'h0, 1'b1, fr == NO}, {30'h0, o_ack, o_discard});
        if (!wr)
            chk("rdata", (fr == NO) ? 32'h0 : rd, o_rdata);
    endtask : acc

    // pulse the instruction inputs for one cycle, then check the window
    task automatic instr(input logic op, input logic cl, input logic ce, input logic exp);
        @(negedge i_mclk);
        i_open_instr <= op;
        i_close_instr <= cl;
        i_ce <= ce;
        @(negedge i_mclk);
        i_open_instr <= 1'b0;
        i_close_instr <= 1'b0;
        i_ce <= 1'b1;
        win = exp;
        chk("window", {31'h0, exp}, {31'h0, o_window_open});
    endtask : instr

    task automatic t_frame0();
        acc(1'b0, 1'b0, 22'h0c00, F0);
        acc(1'b0, 1'b1, 22'h0c3e, F0);
        acc(1'b1, 1'b1, 22'h0b00, F0);
        acc(1'b0, 1'b0, 22'h0b0f, F0);
    endtask : t_frame0

    task automatic t_protect();
        acc(1'b1, 1'b0, 22'h0ae0, NO);
        acc(1'b1, 1'b1, 22'h6fe0, NO);
        acc(1'b0, 1'b0, 22'h0aef, F0);
        instr(1'b1, 1'b0, 1'b0, 1'b0);
        instr(1'b1, 1'b1, 1'b1, 1'b0);
        instr(1'b1, 1'b0, 1'b1, 1'b1);
        acc(1'b1, 1'b0, 22'h0ae0, F0);
        acc(1'b1, 1'b1, 22'h6ffe, F1);
        instr(1'b0, 1'b1, 1'b1, 1'b0);
        acc(1'b1, 1'b0, 22'h0aef, NO);
        acc(1'b1, 1'b0, 22'h6fff, NO);
    endtask : t_protect

    task automatic t_flash();
        instr(1'b1, 1'b0, 1'b1, 1'b1);
        acc(1'b0, 1'b0, 22'h0a80, NO);
        acc(1'b1, 1'b0, 22'h0a80, NO);
        i_csm_unlocked <= 1'b1;
        acc(1'b0, 1'b1, 22'h0a80, F0);
        acc(1'b1, 1'b0, 22'h0adf, F0);
        instr(1'b0, 1'b1, 1'b1, 1'b0);
        acc(1'b1, 1'b0, 22'h0adf, NO);
        acc(1'b0, 1'b0, 22'h0adf, F0);
    endtask : t_flash

    task automatic t_can();
        acc(1'b0, 1'b0, 22'h6000, NO);
        acc(1'b1, 1'b1, 22'h6000, F1);
        acc(1'b0, 1'b1, 22'h62fe, F1);
        acc(1'b1, 1'b0, 22'h62fe, NO);
        acc(1'b0, 1'b1, 22'h6201, NO);
        acc(1'b1, 1'b0, 22'h6100, F1);
        acc(1'b0, 1'b0, 22'h63ff, F1);
    endtask : t_can

    task automatic t_frame2();
        acc(1'b0, 1'b0, 22'h7050, F2);
        acc(1'b1, 1'b0, 22'h792f, F2);
        acc(1'b0, 1'b0, 22'h7010, F2);
        acc(1'b0, 1'b1, 22'h7010, NO);
        acc(1'b1, 1'b1, 22'h7100, NO);
        acc(1'b1, 1'b0, 22'h6800, F1);
        acc(1'b1, 1'b1, 22'h697e, F1);
        acc(1'b0, 1'b0, 22'h6980, NO);
        acc(1'b0, 1'b0, 22'h0a00, NO);
        acc(1'b1, 1'b1, 22'h7930, NO);
    endtask : t_frame2

    // close retires with a read, a protected write follows back to back
    task automatic t_pipeline();
        instr(1'b1, 1'b0, 1'b1, 1'b1);
        @(negedge i_mclk);
        i_close_instr <= 1'b1;
        i_req <= '{valid: 1'b1, write: 1'b0, wide: 1'b0, addr: 22'h7050, wdata: 32'h0};
        @(negedge i_mclk);
        i_close_instr <= 1'b0;
        i_req <= '{valid: 1'b1, write: 1'b1, wide: 1'b0, addr: 22'h0ae0, wdata: 32'h0};
        chk("old window", 32'h3, {30'h0, f2_acc.valid, f2_acc.priv});
        win = 1'b0;
        @(negedge i_mclk);
        i_req.valid <= 1'b0;
        chk("pipe strobes", 32'h0, {29'h0, f0_acc.valid, f1_acc.valid, f2_acc.valid});
        chk("pipe answer", 32'h2, {30'h0, o_ack, o_discard});
        chk("pipe rdata", {16'h0, 16'h7050 ^ 16'h5a5a}, o_rdata);
        @(negedge i_mclk);
        chk("pipe refused", 32'h3, {30'h0, o_ack, o_discard});
        chk("pipe zero", 32'h0, o_rdata);
    endtask : t_pipeline

    initial begin
        repeat (6) @(posedge i_mclk);
        @(negedge i_mclk);
        i_rst_n <= 1'b1;
        t_frame0();
        t_protect();
        t_flash();
        t_can();
        t_frame2();
        t_pipeline();
        finish_test();
    end

    // the whole run needs some 130 cycles
    initial begin
        #(20 * 2000);
        fail_count++;
        finish_test();
    end
endmodule : pfd_frame_router_tb

`default_nettype wire
